/* logic/sorc_map.vh */
// register offsets, field positions and reset values of the output and
// reference configuration bank; assumes an 8-bit address, 8-bit data port.
// Notes on behaviour
// - A 4-bit monitor source field at bits 7:4 of 0x20 resets to 1 and picks the monitor pin signal while monitoring is on.
// - Source codes 1 to 7 route lock detect, pump up, pump down, halved reference, halved feedback, oscillator test and a reserved low.
// - Codes 9 and 10 route the halved calibration reference band and halved calibration feedback band signals.
// - Code 0 floats the pin only while monitoring is off, and code 8 drives the pin high.
// - Bit 3 of 0x20 resets to 0; at 0 the pin carries serial read data, at 1 the selected monitor signal.
// - Bit 2 of 0x20 resets to 1 and selects 3.3 V logic when 1 and 1.8 V logic when 0.
// - Bit 6 of 0x22 resets to 0 and selects a differential reference input when 1.
// - Bit 5 of 0x22 resets to 0 and enables the reference doubler when 1.
// - Bit 4 of 0x22 resets to 0 and enables the reference halving stage when 1.
// - Bit 1 of 0x23 resets to 0 and selects software-written filter coefficients when 1.
// - In 0x24 bits 6:4 reset to 0 pick the output divide ratio and bit 7 resets to 1 feeds back the fundamental.
// - Bit 5 of 0x25 resets to 0 and makes the divider field double buffered when 1.
// - Bits 4 and 3 of 0x25 reset to 0 and turn on the quadrupler and doubler paths.
// - Bit 2 of 0x25 resets to 1 and enables the main differential output pair.
// - Bits 1:0 of 0x25 reset to 3 and select output power from -4 to 5 dBm.
`ifndef SORC_MAP_VH
`define SORC_MAP_VH
`define SORC_ADDR_MON 8'h20
`define SORC_ADDR_REF 8'h22
`define SORC_ADDR_TRK 8'h23
`define SORC_ADDR_FB 8'h24
`define SORC_ADDR_OUT 8'h25
`define SORC_MASK_MON 8'hfc
`define SORC_MASK_REF 8'h70
`define SORC_MASK_TRK 8'h32
`define SORC_MASK_FB 8'hf0
`define SORC_MASK_OUT 8'hbf
`define SORC_RST_MON 8'h14
`define SORC_RST_REF 8'h00
`define SORC_RST_TRK 8'h00
`define SORC_RST_FB 8'h80
`define SORC_RST_OUT 8'h07
`define SORC_RST_DIV 3'h0
`define SORC_SRC_HIZ 4'h0
`define SORC_SRC_LOCK 4'h1
`define SORC_SRC_CPUP 4'h2
`define SORC_SRC_CPDN 4'h3
`define SORC_SRC_RDIV 4'h4
`define SORC_SRC_NDIV 4'h5
`define SORC_SRC_TEST 4'h6
`define SORC_SRC_RSVD 4'h7
`define SORC_SRC_HIGH 4'h8
`define SORC_SRC_CALR 4'h9
`define SORC_SRC_CALN 4'ha
`define SORC_MON_SRC_HI 7
`define SORC_MON_SRC_LO 4
`define SORC_BIT_MON_EN 3
`define SORC_BIT_LEVEL 2
`define SORC_BIT_REF_MODE 6
`define SORC_BIT_REF_DBL 5
`define SORC_BIT_REF_HALF 4
`define SORC_BIT_COEF 1
`define SORC_BIT_FB_SRC 7
`define SORC_DIV_HI 6
`define SORC_DIV_LO 4
`define SORC_BIT_SHADOW 5
`define SORC_BIT_QUAD 4
`define SORC_BIT_DBL 3
`define SORC_BIT_MAIN 2
`define SORC_PWR_HI 1
`define SORC_PWR_LO 0
`endif

/* logic/sorc_regs.v */
// configuration bank for monitor pin, reference path, feedback and output
// stage; assumes a decoded serial interface delivering byte writes/reads
// synchronous to mclk, and internal monitor signals synchronous as well.
`include "sorc_map.vh"
module sorc_regs (
  input wire mclk,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  output reg rd_hit,
  input wire spi_read_data,
  input wire buffered_update,
  input wire lock_detect,
  input wire pump_up,
  input wire pump_down,
  input wire ref_div_out,
  input wire fb_div_out,
  input wire osc_test,
  input wire cal_ref_band,
  input wire cal_fb_band,
  output reg monitor_pin_out,
  output reg monitor_pin_oe,
  output reg monitor_logic_level_select,
  output reg reference_input_mode,
  output reg reference_doubler_enable,
  output reg reference_halve_enable,
  output reg filter_coef_manual,
  output reg feedback_source_select,
  output reg [2:0] output_divider_select,
  output reg divider_shadow_enable,
  output reg quadrupler_path_enable,
  output reg doubler_path_enable,
  output reg main_output_enable,
  output reg [1:0] output_power_level
);
  reg [7:0] mon_q;
  reg [7:0] ref_q;
  reg [7:0] trk_q;
  reg [7:0] fb_q;
  reg [7:0] out_q;
  reg [2:0] div_q;
  reg sel_d;
  reg mon_d;
  reg oe_d;
  reg [7:0] rdata_d;
  wire rdiv_half;
  wire ndiv_half;
  wire calr_half;
  wire caln_half;
  wire [3:0] src;
  wire mon_en;
  wire level_sel;
  wire ref_mode;
  wire ref_dbl;
  wire ref_half;
  wire coef_manual;
  wire fb_src;
  wire [2:0] div_field;
  wire shadow_on;
  wire quad_on;
  wire dbl_on;
  wire main_on;
  wire [1:0] power_code;
  wire wr_mon;
  wire wr_ref;
  wire wr_trk;
  wire wr_fb;
  wire wr_out;

  // field views of the stored registers
  assign src = mon_q[`SORC_MON_SRC_HI:`SORC_MON_SRC_LO];
  assign mon_en = mon_q[`SORC_BIT_MON_EN];
  assign level_sel = mon_q[`SORC_BIT_LEVEL];
  assign ref_mode = ref_q[`SORC_BIT_REF_MODE];
  assign ref_dbl = ref_q[`SORC_BIT_REF_DBL];
  assign ref_half = ref_q[`SORC_BIT_REF_HALF];
  assign coef_manual = trk_q[`SORC_BIT_COEF];
  assign fb_src = fb_q[`SORC_BIT_FB_SRC];
  assign div_field = fb_q[`SORC_DIV_HI:`SORC_DIV_LO];
  assign shadow_on = out_q[`SORC_BIT_SHADOW];
  assign quad_on = out_q[`SORC_BIT_QUAD];
  assign dbl_on = out_q[`SORC_BIT_DBL];
  assign main_on = out_q[`SORC_BIT_MAIN];
  assign power_code = out_q[`SORC_PWR_HI:`SORC_PWR_LO];

  // one write strobe per mapped byte; other addresses are dropped
  assign wr_mon = wr_en && (addr == `SORC_ADDR_MON);
  assign wr_ref = wr_en && (addr == `SORC_ADDR_REF);
  assign wr_trk = wr_en && (addr == `SORC_ADDR_TRK);
  assign wr_fb = wr_en && (addr == `SORC_ADDR_FB);
  assign wr_out = wr_en && (addr == `SORC_ADDR_OUT);

  // each register keeps only its writable bits, so reserved bits read 0
  // monitor pin control
  always @(posedge mclk) begin
    if (rst) begin
      mon_q <= `SORC_RST_MON;
    end else if (wr_mon) begin
      mon_q <= wdata & `SORC_MASK_MON;
    end
  end

  // reference input
  always @(posedge mclk) begin
    if (rst) begin
      ref_q <= `SORC_RST_REF;
    end else if (wr_ref) begin
      ref_q <= wdata & `SORC_MASK_REF;
    end
  end

  // tracking filter
  always @(posedge mclk) begin
    if (rst) begin
      trk_q <= `SORC_RST_TRK;
    end else if (wr_trk) begin
      trk_q <= wdata & `SORC_MASK_TRK;
    end
  end

  // feedback source and divider field
  always @(posedge mclk) begin
    if (rst) begin
      fb_q <= `SORC_RST_FB;
    end else if (wr_fb) begin
      fb_q <= wdata & `SORC_MASK_FB;
    end
  end

  // output stage
  always @(posedge mclk) begin
    if (rst) begin
      out_q <= `SORC_RST_OUT;
    end else if (wr_out) begin
      out_q <= wdata & `SORC_MASK_OUT;
    end
  end

  // applied divider: follows the field directly, or, with the shadow on,
  // only at the update event so a half-written ratio never reaches the
  // output divider
  always @(posedge mclk) begin
    if (rst) begin
      div_q <= `SORC_RST_DIV;
    end else if (!shadow_on) begin
      if (wr_fb) begin
        div_q <= wdata[`SORC_DIV_HI:`SORC_DIV_LO];
      end else begin
        div_q <= div_field;
      end
    end else if (buffered_update) begin
      div_q <= div_field;
    end
  end

  // halved copies of the divider and calibration signals for the pin
  sorc_halver u_rdiv_half (
    .mclk(mclk),
    .rst(rst),
    .sig_in(ref_div_out),
    .half_q(rdiv_half)
  );

  sorc_halver u_ndiv_half (
    .mclk(mclk),
    .rst(rst),
    .sig_in(fb_div_out),
    .half_q(ndiv_half)
  );

  sorc_halver u_calr_half (
    .mclk(mclk),
    .rst(rst),
    .sig_in(cal_ref_band),
    .half_q(calr_half)
  );

  sorc_halver u_caln_half (
    .mclk(mclk),
    .rst(rst),
    .sig_in(cal_fb_band),
    .half_q(caln_half)
  );

  // source multiplexer for the monitor function
  always @* begin
    sel_d = 1'b0;
    case (src)
      `SORC_SRC_LOCK: sel_d = lock_detect;
      `SORC_SRC_CPUP: sel_d = pump_up;
      `SORC_SRC_CPDN: sel_d = pump_down;
      `SORC_SRC_RDIV: sel_d = rdiv_half;
      `SORC_SRC_NDIV: sel_d = ndiv_half;
      `SORC_SRC_TEST: sel_d = osc_test;
      `SORC_SRC_HIGH: sel_d = 1'b1;
      `SORC_SRC_CALR: sel_d = calr_half;
      `SORC_SRC_CALN: sel_d = caln_half;
      default: sel_d = 1'b0;
    endcase
  end

  // with the monitor function off the pin returns serial read data; only
  // then may code 0 release it
  always @* begin
    mon_d = sel_d;
    oe_d = 1'b1;
    if (!mon_en) begin
      mon_d = spi_read_data;
      oe_d = (src != `SORC_SRC_HIZ);
    end
  end

  always @* begin
    case (addr)
      `SORC_ADDR_MON: rdata_d = mon_q;
      `SORC_ADDR_REF: rdata_d = ref_q;
      `SORC_ADDR_TRK: rdata_d = trk_q;
      `SORC_ADDR_FB: rdata_d = fb_q;
      `SORC_ADDR_OUT: rdata_d = out_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // read port: data stands for the one cycle after the request
  always @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
      rd_hit <= 1'b0;
    end else begin
      rdata <= rd_en ? rdata_d : 8'h00;
      rd_hit <= rd_en;
    end
  end

  // monitor pin, registered so it changes only on mclk
  always @(posedge mclk) begin
    if (rst) begin
      monitor_pin_out <= 1'b0;
      monitor_pin_oe <= 1'b1;
    end else begin
      monitor_pin_out <= mon_d;
      monitor_pin_oe <= oe_d;
    end
  end

  // configuration levels, one cycle behind their registers
  always @(posedge mclk) begin
    if (rst) begin
      monitor_logic_level_select <= 1'b1;
      reference_input_mode <= 1'b0;
      reference_doubler_enable <= 1'b0;
      reference_halve_enable <= 1'b0;
      filter_coef_manual <= 1'b0;
      feedback_source_select <= 1'b1;
      output_divider_select <= `SORC_RST_DIV;
      divider_shadow_enable <= 1'b0;
      quadrupler_path_enable <= 1'b0;
      doubler_path_enable <= 1'b0;
      main_output_enable <= 1'b1;
      output_power_level <= 2'h3;
    end else begin
      monitor_logic_level_select <= level_sel;
      reference_input_mode <= ref_mode;
      reference_doubler_enable <= ref_dbl;
      reference_halve_enable <= ref_half;
      filter_coef_manual <= coef_manual;
      feedback_source_select <= fb_src;
      output_divider_select <= div_q;
      divider_shadow_enable <= shadow_on;
      quadrupler_path_enable <= quad_on;
      doubler_path_enable <= dbl_on;
      main_output_enable <= main_on;
      output_power_level <= power_code;
    end
  end
endmodule

// divides a synchronous input by two: toggles on each rising edge;
// the edge memory resets low like the idle input, so no false edge
module sorc_halver (
  input wire mclk,
  input wire rst,
  input wire sig_in,
  output reg half_q
);
  reg prev_q;

  always @(posedge mclk) begin
    if (rst) begin
      prev_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      prev_q <= sig_in;
      if (sig_in && !prev_q) begin
        half_q <= !half_q;
      end
    end
  end
endmodule

/* sim/sorc_regs_asserts.sv */
// checker for the sorc_regs ports: reads, config outputs, monitor pin
// assumes it is bound into sorc_regs; rst is synchronous, active high
module sorc_regs_chk (
  input wire mclk,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire rd_hit,
  input wire buffered_update,
  input wire spi_read_data,
  input wire monitor_pin_out,
  input wire monitor_pin_oe,
  input wire [2:0] output_divider_select,
  input wire divider_shadow_enable,
  input wire main_output_enable,
  input wire [1:0] output_power_level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic w25_q;
  wire w20 = wr_en && addr == 8'h20;
  wire w24 = wr_en && addr == 8'h24 && !w25_q;
  wire unm = addr < 8'h20 || addr == 8'h21 || addr > 8'h25;
  // shadow flag lags its register, so skip checks just after a 0x25 write
  always @(posedge mclk) w25_q <= wr_en && addr == 8'h25;
  a_unmapped_read_zero: assert property (
    rd_en && unm |=> rd_hit && rdata == 8'h00) else $error("unmapped read");
  a_read_after_write: assert property (
    w20 ##1 rd_en && addr == 8'h20 |=> rdata == ($past(wdata, 2) & 8'hfc))
    else $error("monitor register readback");
  a_out_stage_write: assert property (
    wr_en && addr == 8'h25 |-> ##2 {5'h00, main_output_enable,
    output_power_level} == ($past(wdata, 2) & 8'h07)) else $error("out stage");
  a_code_high_drive: assert property (
    w20 && wdata[7:3] == 5'h11 |-> ##2 monitor_pin_out && monitor_pin_oe)
    else $error("code eight not high");
  a_hiz_when_off: assert property (
    w20 && wdata[7:3] == 5'h00 |-> ##2 !monitor_pin_oe) else $error("no hiz");
  a_spi_pin_drive: assert property (
    w20 && !wdata[3] && wdata[7:4] != 4'h0 |-> ##2 monitor_pin_oe &&
    monitor_pin_out == $past(spi_read_data)) else $error("spi path");
  a_shadow_hold: assert property (
    w24 && divider_shadow_enable && !buffered_update ##1 !buffered_update
    |=> $stable(output_divider_select)) else $error("shadow leaked");
  a_div_direct: assert property (
    w24 && !divider_shadow_enable |-> ##2 {5'h00, output_divider_select} ==
    (($past(wdata, 2) >> 4) & 8'h07)) else $error("divider not direct");
  a_reset_defaults: assert property (
    $fell(rst) |-> main_output_enable && output_power_level == 2'h3 &&
    output_divider_select == 3'h0) else $error("reset defaults");
  c_unmapped: cover property (rd_en && unm);
  c_shadow_write: cover property (w24 && divider_shadow_enable);
  c_update: cover property (buffered_update && divider_shadow_enable);
endmodule
bind sorc_regs sorc_regs_chk u_chk (.*);

/* sim/tb.sv */
// self-checking bench for sorc_regs: register access and pin behaviour
// assumes the bank and its checker are compiled alongside
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, wr_en = 0, rd_en = 0, spi_read_data = 0;
  logic buffered_update = 0, lock_detect = 0, pump_up = 0, pump_down = 0;
  logic osc_test = 0, ref_div_out = 0, fb_div_out = 0, cal_ref_band = 0;
  logic cal_fb_band = 0, exp_pin;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  wire [7:0] rdata;
  wire [2:0] output_divider_select;
  wire [1:0] output_power_level;
  wire rd_hit, monitor_pin_out, monitor_pin_oe, monitor_logic_level_select;
  wire reference_input_mode, reference_doubler_enable, reference_halve_enable;
  wire filter_coef_manual, feedback_source_select, divider_shadow_enable;
  wire quadrupler_path_enable, doubler_path_enable, main_output_enable;
  int n_mismatch = 0, tests_run = 0;
  logic [7:0] ads [5] = '{8'h20, 8'h22, 8'h23, 8'h24, 8'h25};
  logic [7:0] dfl [5] = '{8'h14, 8'h00, 8'h00, 8'h80, 8'h07};
  logic [7:0] msk [5] = '{8'hfc, 8'h70, 8'h32, 8'hf0, 8'hbf};
  logic [3:0] ks [4] = '{4'h4, 4'h5, 4'h9, 4'ha};
  sorc_regs uut (.*);
  always #4 mclk = ~mclk;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: %h %h", $time, g, e); end end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    {wr_en, addr, wdata} = {1'b1, a, d};
    step(1);
    wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    step(1);
    {rd_en, addr} = {1'b1, a};
    step(1);
    rd_en = 0;
    `CHK(rdata, e)
    `CHK(rd_hit, 1'b1)
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    step(5);
    rst = 0;
    for (int i = 0; i < 5; i++) rd(ads[i], dfl[i]);
    rd(8'h21, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 5; i++) wr(ads[i], 8'hff);
    wr(8'h26, 8'hff);
    step(2);
    `CHK({reference_input_mode, reference_doubler_enable,
      quadrupler_path_enable, reference_halve_enable, filter_coef_manual,
      doubler_path_enable, monitor_logic_level_select}, 7'h7f)
    for (int i = 0; i < 5; i++) rd(ads[i], msk[i]);
    rd(8'h26, 8'h00);
    $display("mask test done");
    wr(8'h24, 8'h30);
    step(2);
    `CHK(output_divider_select, 3'h7)
    step(1);
    buffered_update = 1;
    step(1);
    buffered_update = 0;
    step(2);
    `CHK(output_divider_select, 3'h3)
    wr(8'h25, 8'h07);
    step(2);
    `CHK({divider_shadow_enable, main_output_enable, output_power_level},
      4'h7)
    wr(8'h24, 8'h50);
    step(2);
    `CHK({feedback_source_select, output_divider_select}, 4'h5)
    wr(8'h25, 8'h02);
    step(2);
    `CHK({main_output_enable, output_power_level}, 3'h2)
    $display("divider test done");
    for (int p = 0; p < 2; p++) begin
      {lock_detect, pump_up, pump_down, osc_test} = p[0] ? 4'ha : 4'h5;
      for (int c = 0; c < 16; c++) begin
        wr(8'h20, {c[3:0], 4'hc});
        step(2);
        case (c)
          1: exp_pin = lock_detect;
          2: exp_pin = pump_up;
          3: exp_pin = pump_down;
          6: exp_pin = osc_test;
          8: exp_pin = 1'b1;
          default: exp_pin = 1'b0;
        endcase
        if (!(c inside {4, 5, 9, 10}))
          `CHK({monitor_pin_oe, monitor_pin_out}, {1'b1, exp_pin})
      end
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'h20, {ks[k], 4'hc});
      step(2);
      `CHK(monitor_pin_out, 1'b0)
      {ref_div_out, fb_div_out, cal_ref_band, cal_fb_band} = 4'h8 >> k;
      step(1);
      {ref_div_out, fb_div_out, cal_ref_band, cal_fb_band} = 4'h0;
      step(2);
      `CHK({monitor_pin_oe, monitor_pin_out}, 2'h3)
    end
    spi_read_data = 1;
    wr(8'h20, 8'h14);
    rd(8'h20, 8'h14);
    `CHK({monitor_pin_oe, monitor_pin_out}, 2'h3)
    wr(8'h20, 8'h04);
    step(2);
    `CHK(monitor_pin_oe, 1'b0)
    $display("monitor test done");
    report_and_stop;
  end
endmodule
